// ==== hotswap_pkg.sv ====
// Summary of operation
// - drive reverse block gate high once main rail differential exceeds turn-on level.
// - drop reverse block gate once differential falls below turn-off level.
// - oring enable bit cleared disables reverse block gate drive entirely.
// - high power select bit picks the positive turn-off level, else default negative.
// - discharge wait bit set holds a newly enabled channel off until its output is discharged.
// - bleed switch closes only while channel disabled and its bleed bit set.
// - each channel owns a fault timer started when current limit becomes active.
// - current limit lasting to timer expiry turns pass FET off, sets fault flag.
// - fault time is a 5-bit code in base steps, one step per LSB.
// - main code in bits 4..0 of register 4, aux code in register 5.
// - retry select cleared: faulted channel stays off until disabled and re-enabled.
// - retry select set: faulted channel retries after a hundred fault times.
package hotswap_pkg;
  // ==========================================================
  // register map
  localparam logic [7:0] ADDR_CONTROL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h02;
  localparam logic [7:0] ADDR_FAULT_TIME_MAIN = 8'h04;
  localparam logic [7:0] ADDR_FAULT_TIME_AUX = 8'h05;
  localparam int CTRL_ORING_EN = 0;
  localparam int CTRL_HIGH_POWER = 1;
  localparam int CTRL_DS_MAIN = 2;
  localparam int CTRL_DS_AUX = 3;
  localparam int CTRL_BLEED_MAIN = 4;
  localparam int CTRL_BLEED_AUX = 5;
  localparam int CTRL_RETRY = 6;
  localparam int STAT_FLT_MAIN = 0;
  localparam int STAT_FLT_AUX = 1;
  localparam int STAT_GATE = 2;
  localparam int STAT_PASS_MAIN = 3;
  localparam int STAT_PASS_AUX = 4;
  localparam int FT_MSB = 4;
  localparam logic [7:0] CONTROL_RESET = 8'h01;
  localparam logic [4:0] FAULT_TIME_RESET = 5'h01;
  // ==========================================================
  // pin vector positions (all asynchronous to clk)
  localparam int PIN_EN_MAIN = 0;
  localparam int PIN_EN_AUX = 1;
  localparam int PIN_ABOVE_ON = 2;
  localparam int PIN_BELOW_OFF = 3;
  localparam int PIN_BELOW_OFF_HP = 4;
  localparam int PIN_CL_MAIN = 5;
  localparam int PIN_CL_AUX = 6;
  localparam int PIN_DIS_MAIN = 7;
  localparam int PIN_DIS_AUX = 8;
  localparam int PIN_COUNT = 9;
  // ==========================================================
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int FAULT_STEP_NS = 450000;
  localparam int FAULT_STEP_CYCLES = FAULT_STEP_NS / CLK_PERIOD_NS;
  localparam int RETRY_FACTOR = 100;
  // ==========================================================
  // states
  typedef enum logic [3:0] {
    BUS_IDLE = 4'h0, BUS_ADDR = 4'h1, BUS_ACK_ADDR = 4'h2, BUS_REG = 4'h3,
    BUS_ACK_REG = 4'h4, BUS_WDATA = 4'h5, BUS_ACK_WR = 4'h6, BUS_RDATA = 4'h7,
    BUS_RACK = 4'h8
  } bus_state_type;
  typedef enum logic [1:0] {
    CH_OFF = 2'b00, CH_WAIT = 2'b01, CH_ON = 2'b10, CH_FAULT = 2'b11
  } ch_state_type;
endpackage

// ==== channel_ctrl.sv ====
`timescale 1ns/10ps
module channel_ctrl #(
  parameter int STEP_CYCLES = hotswap_pkg::FAULT_STEP_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // synchronised status
  input wire logic enable,
  input wire logic current_limit,
  input wire logic below_discharge,
  // configuration
  input wire logic discharge_wait,
  input wire logic retry_select,
  input wire logic [4:0] fault_time_code,
  // results
  output logic pass_on,
  output logic fault_flag
);
  localparam int PW = $clog2(STEP_CYCLES + 1);
  typedef struct packed {
    hotswap_pkg::ch_state_type state;
    logic [PW-1:0] pre;
    logic [11:0] step;
    logic [4:0] lat;
    logic flag;
    logic pass;
  } ch_type;
  ch_type st, next_st;
  logic tick;
  logic [11:0] step_inc;
  logic [11:0] retry_lim;

  // ==========================================================
  // timer and channel sequence
  always_comb begin
    next_st = st;
    tick = (st.pre == PW'(STEP_CYCLES - 1));
    step_inc = st.step + 12'h001;
    retry_lim = 12'(st.lat) * 12'(hotswap_pkg::RETRY_FACTOR);
    next_st.pre = tick ? '0 : st.pre + PW'(1);
    if (tick) begin
      next_st.step = step_inc;
    end
    case (st.state)
      hotswap_pkg::CH_OFF: begin
        next_st.pre = '0;
        next_st.step = 12'h000;
        if (enable) begin
          next_st.flag = 1'b0;
          next_st.state = hotswap_pkg::CH_WAIT;
        end
      end
      hotswap_pkg::CH_WAIT: begin
        if (!enable) begin
          next_st.state = hotswap_pkg::CH_OFF;
        end else if (!discharge_wait || below_discharge) begin
          next_st.state = hotswap_pkg::CH_ON;
        end
      end
      hotswap_pkg::CH_ON: begin
        if (!enable) begin
          next_st.state = hotswap_pkg::CH_OFF;
        end else if (!current_limit) begin
          // code follows the register until limit starts, then stays frozen
          next_st.lat = fault_time_code;
          next_st.pre = '0;
          next_st.step = 12'h000;
        end else if (tick && step_inc == 12'(st.lat)) begin
          next_st.state = hotswap_pkg::CH_FAULT;
          next_st.flag = 1'b1;
          next_st.step = 12'h000;
        end
      end
      hotswap_pkg::CH_FAULT: begin
        if (!enable) begin
          next_st.state = hotswap_pkg::CH_OFF;
        end else if (!retry_select) begin
          next_st.pre = '0;
          next_st.step = 12'h000;
        end else if (tick && step_inc == retry_lim) begin
          next_st.state = hotswap_pkg::CH_ON;
          next_st.step = 12'h000;
        end
      end
      default: begin
        next_st.state = hotswap_pkg::CH_OFF;
      end
    endcase
    next_st.pass = (next_st.state == hotswap_pkg::CH_ON);
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{state: hotswap_pkg::CH_OFF, pre: '0, step: 12'h000,
              lat: hotswap_pkg::FAULT_TIME_RESET, flag: 1'b0, pass: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign pass_on = st.pass;
  assign fault_flag = st.flag;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_ds_holds_off: assert property (st.state == hotswap_pkg::CH_WAIT && enable && discharge_wait
      && !below_discharge |=> !pass_on) else $error("turned on before discharge");
  a_fault_kills_pass: assert property ($rose(fault_flag) |-> !pass_on && $past(pass_on))
    else $error("fault flag without pass turn-off");
  a_timer_expiry: assert property (st.state == hotswap_pkg::CH_ON && enable && current_limit
      && tick && step_inc == 12'(st.lat) |=> fault_flag && !pass_on)
    else $error("fault timer expiry missed");
  a_timer_clear: assert property (st.state == hotswap_pkg::CH_ON && enable && !current_limit
      |=> st.step == 12'h000 && st.pre == '0) else $error("timer not cleared");
  a_code_frozen: assert property (st.state == hotswap_pkg::CH_ON && current_limit
      |=> $stable(st.lat)) else $error("code changed during limit");
  a_latch_off: assert property (st.state == hotswap_pkg::CH_FAULT && enable && !retry_select
      |=> st.state == hotswap_pkg::CH_FAULT && fault_flag && !pass_on)
    else $error("latched fault left");
  a_retry_wait: assert property ($rose(st.state == hotswap_pkg::CH_FAULT) && retry_select
      |-> !pass_on [*8]) else $error("retry came too soon");
endmodule

// ==== hotswap_fault_oring_ctrl.sv ====
`timescale 1ns/10ps
module hotswap_fault_oring_ctrl #(
  parameter int STEP_CYCLES = hotswap_pkg::FAULT_STEP_CYCLES,
  parameter logic [6:0] DEV_ADDR = 7'h10
) (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // two-wire register bus, sda open drain
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  // channel enables and analog comparator results
  input wire logic en_main,
  input wire logic en_aux,
  input wire logic diff_above_on,
  input wire logic diff_below_off,
  input wire logic diff_below_off_hp,
  input wire logic current_limit_main,
  input wire logic current_limit_aux,
  input wire logic output_rail_main_low,
  input wire logic output_rail_aux_low,
  // drivers
  output logic reverse_block_gate,
  output logic pass_on_main,
  output logic pass_on_aux,
  output logic bleed_switch_main_rail,
  output logic bleed_switch_aux_rail,
  output logic [1:0] channel_fault_flag
);
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic scl_d;
    logic sda_d;
    logic [hotswap_pkg::PIN_COUNT-1:0] pin_s1;
    logic [hotswap_pkg::PIN_COUNT-1:0] pin_s2;
    hotswap_pkg::bus_state_type bus;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic rw;
    logic oe;
    logic [7:0] ctrl;
    logic [4:0] ft_main;
    logic [4:0] ft_aux;
    logic gate;
    logic bleed_main;
    logic bleed_aux;
  } top_type;
  top_type st, next_st;
  logic scl_rise, scl_fall, bus_start, bus_stop, sda;
  logic below_sel;
  logic [7:0] rd_cur, rd_next;
  logic [hotswap_pkg::PIN_COUNT-1:0] pin;
  logic [hotswap_pkg::PIN_COUNT-1:0] pin_raw;

  function automatic logic [7:0] reg_read(input logic [7:0] a, input top_type s,
                                          input logic pm, input logic pa,
                                          input logic [1:0] flt);
    logic [7:0] v;
    v = 8'h00;
    case (a)
      hotswap_pkg::ADDR_CONTROL: v = s.ctrl;
      hotswap_pkg::ADDR_STATUS: begin
        v[hotswap_pkg::STAT_FLT_MAIN] = flt[0];
        v[hotswap_pkg::STAT_FLT_AUX] = flt[1];
        v[hotswap_pkg::STAT_GATE] = s.gate;
        v[hotswap_pkg::STAT_PASS_MAIN] = pm;
        v[hotswap_pkg::STAT_PASS_AUX] = pa;
      end
      hotswap_pkg::ADDR_FAULT_TIME_MAIN: v = {3'h0, s.ft_main};
      hotswap_pkg::ADDR_FAULT_TIME_AUX: v = {3'h0, s.ft_aux};
      default: v = 8'h00;
    endcase
    return v;
  endfunction

  assign pin_raw = {output_rail_aux_low, output_rail_main_low, current_limit_aux,
                    current_limit_main, diff_below_off_hp, diff_below_off, diff_above_on,
                    en_aux, en_main};
  assign pin = st.pin_s2;
  assign sda = st.sda_s[1];
  assign scl_rise = st.scl_s[1] & ~st.scl_d;
  assign scl_fall = ~st.scl_s[1] & st.scl_d;
  assign bus_start = st.scl_s[1] & st.scl_d & st.sda_d & ~sda;
  assign bus_stop = st.scl_s[1] & st.scl_d & ~st.sda_d & sda;
  assign rd_cur = reg_read(st.ptr, st, pass_on_main, pass_on_aux, channel_fault_flag);
  assign rd_next = reg_read(st.ptr + 8'h01, st, pass_on_main, pass_on_aux,
                            channel_fault_flag);

  // ==========================================================
  // synchronisers, register bus slave, gate and bleed drive
  always_comb begin
    next_st = st;
    next_st.scl_s = {st.scl_s[0], scl_in};
    next_st.sda_s = {st.sda_s[0], sda_in};
    next_st.scl_d = st.scl_s[1];
    next_st.sda_d = st.sda_s[1];
    next_st.pin_s1 = pin_raw;
    next_st.pin_s2 = st.pin_s1;
    if (bus_stop) begin
      next_st.bus = hotswap_pkg::BUS_IDLE;
      next_st.oe = 1'b0;
    end else if (bus_start) begin
      next_st.bus = hotswap_pkg::BUS_ADDR;
      next_st.cnt = 4'h0;
      next_st.oe = 1'b0;
    end else if (scl_rise) begin
      case (st.bus)
        hotswap_pkg::BUS_ADDR, hotswap_pkg::BUS_REG, hotswap_pkg::BUS_WDATA: begin
          next_st.sh = {st.sh[6:0], sda};
          next_st.cnt = st.cnt + 4'h1;
        end
        hotswap_pkg::BUS_RDATA: next_st.cnt = st.cnt + 4'h1;
        hotswap_pkg::BUS_RACK: begin
          // not acknowledged: master wants no more bytes
          if (sda) begin
            next_st.bus = hotswap_pkg::BUS_IDLE;
          end
        end
        default: begin
        end
      endcase
    end else if (scl_fall) begin
      case (st.bus)
        hotswap_pkg::BUS_ADDR: begin
          if (st.cnt == 4'h8) begin
            if (st.sh[7:1] == DEV_ADDR) begin
              next_st.rw = st.sh[0];
              next_st.bus = hotswap_pkg::BUS_ACK_ADDR;
              next_st.oe = 1'b1;
            end else begin
              next_st.bus = hotswap_pkg::BUS_IDLE;
            end
          end
        end
        hotswap_pkg::BUS_REG: begin
          if (st.cnt == 4'h8) begin
            next_st.ptr = st.sh;
            next_st.bus = hotswap_pkg::BUS_ACK_REG;
            next_st.oe = 1'b1;
          end
        end
        hotswap_pkg::BUS_WDATA: begin
          if (st.cnt == 4'h8) begin
            case (st.ptr)
              hotswap_pkg::ADDR_CONTROL: next_st.ctrl = st.sh;
              hotswap_pkg::ADDR_FAULT_TIME_MAIN: next_st.ft_main = st.sh[hotswap_pkg::FT_MSB:0];
              hotswap_pkg::ADDR_FAULT_TIME_AUX: next_st.ft_aux = st.sh[hotswap_pkg::FT_MSB:0];
              default: begin
              end
            endcase
            next_st.bus = hotswap_pkg::BUS_ACK_WR;
            next_st.oe = 1'b1;
          end
        end
        hotswap_pkg::BUS_ACK_ADDR: begin
          next_st.cnt = 4'h0;
          if (st.rw) begin
            next_st.bus = hotswap_pkg::BUS_RDATA;
            next_st.sh = rd_cur;
            next_st.oe = ~rd_cur[7];
          end else begin
            next_st.bus = hotswap_pkg::BUS_REG;
            next_st.oe = 1'b0;
          end
        end
        hotswap_pkg::BUS_ACK_REG, hotswap_pkg::BUS_ACK_WR: begin
          next_st.cnt = 4'h0;
          next_st.oe = 1'b0;
          next_st.bus = hotswap_pkg::BUS_WDATA;
          if (st.bus == hotswap_pkg::BUS_ACK_WR) begin
            next_st.ptr = st.ptr + 8'h01;
          end
        end
        hotswap_pkg::BUS_RDATA: begin
          if (st.cnt == 4'h8) begin
            next_st.oe = 1'b0;
            next_st.bus = hotswap_pkg::BUS_RACK;
          end else begin
            next_st.sh = {st.sh[6:0], 1'b0};
            next_st.oe = ~st.sh[6];
          end
        end
        hotswap_pkg::BUS_RACK: begin
          next_st.ptr = st.ptr + 8'h01;
          next_st.sh = rd_next;
          next_st.oe = ~rd_next[7];
          next_st.cnt = 4'h0;
          next_st.bus = hotswap_pkg::BUS_RDATA;
        end
        default: begin
        end
      endcase
    end
    // hysteresis: between the two levels the gate keeps its state
    below_sel = st.ctrl[hotswap_pkg::CTRL_HIGH_POWER] ?
                pin[hotswap_pkg::PIN_BELOW_OFF_HP] : pin[hotswap_pkg::PIN_BELOW_OFF];
    if (!st.ctrl[hotswap_pkg::CTRL_ORING_EN]) begin
      next_st.gate = 1'b0;
    end else if (pin[hotswap_pkg::PIN_ABOVE_ON]) begin
      next_st.gate = 1'b1;
    end else if (below_sel) begin
      next_st.gate = 1'b0;
    end
    next_st.bleed_main = ~pin[hotswap_pkg::PIN_EN_MAIN] &
                         st.ctrl[hotswap_pkg::CTRL_BLEED_MAIN];
    next_st.bleed_aux = ~pin[hotswap_pkg::PIN_EN_AUX] &
                        st.ctrl[hotswap_pkg::CTRL_BLEED_AUX];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '{scl_s: 2'h3, sda_s: 2'h3, scl_d: 1'b1, sda_d: 1'b1, pin_s1: '0, pin_s2: '0,
              bus: hotswap_pkg::BUS_IDLE, cnt: 4'h0, sh: 8'h00, ptr: 8'h00, rw: 1'b0,
              oe: 1'b0, ctrl: hotswap_pkg::CONTROL_RESET,
              ft_main: hotswap_pkg::FAULT_TIME_RESET, ft_aux: hotswap_pkg::FAULT_TIME_RESET,
              gate: 1'b0, bleed_main: 1'b0, bleed_aux: 1'b0};
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // channels
  channel_ctrl #(.STEP_CYCLES(STEP_CYCLES)) u_main (
    .clk(clk),
    .rstn(rstn),
    .enable(pin[hotswap_pkg::PIN_EN_MAIN]),
    .current_limit(pin[hotswap_pkg::PIN_CL_MAIN]),
    .below_discharge(pin[hotswap_pkg::PIN_DIS_MAIN]),
    .discharge_wait(st.ctrl[hotswap_pkg::CTRL_DS_MAIN]),
    .retry_select(st.ctrl[hotswap_pkg::CTRL_RETRY]),
    .fault_time_code(st.ft_main),
    .pass_on(pass_on_main),
    .fault_flag(channel_fault_flag[0])
  );
  channel_ctrl #(.STEP_CYCLES(STEP_CYCLES)) u_aux (
    .clk(clk),
    .rstn(rstn),
    .enable(pin[hotswap_pkg::PIN_EN_AUX]),
    .current_limit(pin[hotswap_pkg::PIN_CL_AUX]),
    .below_discharge(pin[hotswap_pkg::PIN_DIS_AUX]),
    .discharge_wait(st.ctrl[hotswap_pkg::CTRL_DS_AUX]),
    .retry_select(st.ctrl[hotswap_pkg::CTRL_RETRY]),
    .fault_time_code(st.ft_aux),
    .pass_on(pass_on_aux),
    .fault_flag(channel_fault_flag[1])
  );

  assign sda_out = 1'b0;
  assign sda_oe = st.oe;
  assign reverse_block_gate = st.gate;
  assign bleed_switch_main_rail = st.bleed_main;
  assign bleed_switch_aux_rail = st.bleed_aux;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  a_gate_disabled: assert property (!st.ctrl[hotswap_pkg::CTRL_ORING_EN]
      |=> !reverse_block_gate) else $error("gate driven while oring off");
  a_gate_turn_on: assert property (st.ctrl[hotswap_pkg::CTRL_ORING_EN]
      && pin[hotswap_pkg::PIN_ABOVE_ON] |=> reverse_block_gate)
    else $error("gate not turned on");
  a_gate_turn_off: assert property (st.ctrl[hotswap_pkg::CTRL_ORING_EN]
      && !pin[hotswap_pkg::PIN_ABOVE_ON] && below_sel |=> !reverse_block_gate)
    else $error("gate not turned off");
  a_gate_hp_level: assert property (st.ctrl[hotswap_pkg::CTRL_ORING_EN] && reverse_block_gate
      && st.ctrl[hotswap_pkg::CTRL_HIGH_POWER] && !pin[hotswap_pkg::PIN_BELOW_OFF_HP]
      |=> reverse_block_gate) else $error("wrong turn-off level used");
  a_bleed_main: assert property (pin[hotswap_pkg::PIN_EN_MAIN]
      |=> !bleed_switch_main_rail) else $error("bleed closed while enabled");
  a_bleed_aux: assert property (!pin[hotswap_pkg::PIN_EN_AUX]
      && st.ctrl[hotswap_pkg::CTRL_BLEED_AUX] |=> bleed_switch_aux_rail)
    else $error("bleed open while disabled");
  a_reg_width: assert property (st.bus == hotswap_pkg::BUS_WDATA && scl_fall
      && st.cnt == 4'h8 && st.ptr == hotswap_pkg::ADDR_FAULT_TIME_MAIN
      |=> st.ft_main == $past(st.sh[4:0])) else $error("fault code write lost");
endmodule

// ==== bus_host.sv ====
`timescale 1ns/10ps
module bus_host (
  // clock
  input wire logic clk,
  // two-wire pins
  input wire logic sda_oe,
  output logic scl,
  output logic sda
);
  logic drv = 1'b1;
  // ====
  // line model
  // pull-up: a released line reads high
  assign sda = drv & !sda_oe;
  initial scl = 1'b1;
  // ====
  // bit and byte level
  // ten clocks a phase keeps above the three the slave needs
  task automatic half();
    repeat (10) @(negedge clk);
  endtask
  task automatic bit_io(input logic b, output logic r);
    drv = b;
    half();
    scl = 1'b1;
    half();
    r = sda;
    scl = 1'b0;
  endtask
  task automatic start();
    drv = 1'b1;
    half();
    scl = 1'b1;
    half();
    drv = 1'b0;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    drv = 1'b0;
    half();
    scl = 1'b1;
    half();
    drv = 1'b1;
    half();
  endtask
  task automatic byte_io(input logic [7:0] v, input logic m, output logic [7:0] r,
                         output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], b);
      r[i] = b;
    end
    bit_io(m, b);
    ack = !b;
  endtask
  // ====
  // register transfers
  task automatic write_reg(input logic [6:0] a, input logic [7:0] rn, input logic [7:0] d,
                           output logic ok);
    logic [7:0] r;
    logic k1, k2, k3;
    start();
    byte_io({a, 1'b0}, 1'b1, r, k1);
    byte_io(rn, 1'b1, r, k2);
    byte_io(d, 1'b1, r, k3);
    stop();
    ok = k1 & k2 & k3;
  endtask
  task automatic read_reg(input logic [6:0] a, input logic [7:0] rn, output logic [7:0] d,
                          output logic ok);
    logic [7:0] r;
    logic k1, k2, k3, k4;
    start();
    byte_io({a, 1'b0}, 1'b1, r, k1);
    byte_io(rn, 1'b1, r, k2);
    start();
    byte_io({a, 1'b1}, 1'b1, r, k3);
    byte_io(8'hff, 1'b1, d, k4);
    stop();
    ok = k1 & k2 & k3;
  endtask
endmodule

// ==== tb_hotswap_fault_oring_ctrl.sv ====
`timescale 1ns/10ps
module tb_hotswap_fault_oring_ctrl;
  localparam int STEP = 10;
  localparam logic [6:0] ADDR = 7'h10;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic scl, sda, sda_out, sda_oe, gate, pm, pa, ok;
  logic above_on = 1'b0, below_off = 1'b0, below_hp = 1'b0;
  logic [1:0] en = 2'h0, cl = 2'h0, low = 2'h0, flt, bl;
  logic [6:0] mon;
  logic [7:0] rd;
  logic [4:0] code;
  int n_errors = 0, check_count = 0, n;
  int seed = 32'hb276b1a5;
  assign mon = {bl, flt, pa, pm, gate};
  initial forever #25 clk = ~clk;
  bus_host host (.clk(clk), .sda_oe(sda_oe), .scl(scl), .sda(sda));
  hotswap_fault_oring_ctrl #(.STEP_CYCLES(STEP), .DEV_ADDR(ADDR)) dut (
    .clk(clk), .rstn(rstn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .en_main(en[0]), .en_aux(en[1]), .diff_above_on(above_on), .diff_below_off(below_off),
    .diff_below_off_hp(below_hp), .current_limit_main(cl[0]), .current_limit_aux(cl[1]),
    .output_rail_main_low(low[0]), .output_rail_aux_low(low[1]),
    .reverse_block_gate(gate), .pass_on_main(pm), .pass_on_aux(pa),
    .bleed_switch_main_rail(bl[0]), .bleed_switch_aux_rail(bl[1]),
    .channel_fault_flag(flt));
  // ====
  // checking helpers
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %b seen %b", nm, e, g);
    end
  endtask
  task automatic cmp_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait; running out ends the run
  task automatic wait_mon(input int i, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (mon[i] !== v && cnt < lim) begin
      @(negedge clk);
      cnt++;
    end
    if (mon[i] !== v) begin
      n_errors++;
      $display("mismatch wait on output %0d expected %b seen %b", i, v, mon[i]);
      test_done();
    end
  endtask
  task automatic wr(input logic [7:0] rn, input logic [7:0] d);
    host.write_reg(ADDR, rn, d, ok);
    cmp_bit("write ack", 1'b1, ok);
  endtask
  task automatic chk_reg(input logic [7:0] rn, input logic [7:0] e);
    host.read_reg(ADDR, rn, rd, ok);
    cmp_bit("read ack", 1'b1, ok);
    cmp_byte("register", e, rd);
  endtask
  // three edges of sync and register, plus margin
  task automatic settle();
    repeat (5) @(negedge clk);
  endtask
  task automatic fault_run(input int c, input logic [4:0] k);
    int t;
    t = k * STEP;
    wr(hotswap_pkg::ADDR_FAULT_TIME_MAIN + 8'(c), {3'b101, k});
    chk_reg(hotswap_pkg::ADDR_FAULT_TIME_MAIN + 8'(c), {3'b000, k});
    en[c] = 1'b1;
    wait_mon(1 + c, 1'b1, 50, n);
    // a burst just short of the fault time must not trip
    cl[c] = 1'b1;
    repeat (t - 3) @(negedge clk);
    cl[c] = 1'b0;
    settle();
    cmp_bit("pass after short limit", 1'b1, mon[1+c]);
    cl[c] = 1'b1;
    wait_mon(3 + c, 1'b1, t + 20, n);
    cmp_bit("fault time window", 1'b1, n >= t && n <= t + 6);
    cmp_bit("pass off at fault", 1'b0, mon[1+c]);
    cl[c] = 1'b0;
  endtask
  // ====
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    settle();
    cmp_bit("sda drive level", 1'b0, sda_out);
    chk_reg(hotswap_pkg::ADDR_CONTROL, hotswap_pkg::CONTROL_RESET);
    chk_reg(hotswap_pkg::ADDR_FAULT_TIME_MAIN, 8'h01);
    chk_reg(hotswap_pkg::ADDR_FAULT_TIME_AUX, 8'h01);
    chk_reg(8'h07, 8'h00);
    host.write_reg(ADDR + 7'h01, 8'h00, 8'h00, ok);
    cmp_bit("foreign address ack", 1'b0, ok);
    $display("test registers done");
    above_on = 1'b1;
    settle();
    cmp_bit("gate on", 1'b1, gate);
    above_on = 1'b0;
    below_hp = 1'b1;
    settle();
    cmp_bit("gate holds default", 1'b1, gate);
    below_off = 1'b1;
    settle();
    cmp_bit("gate off", 1'b0, gate);
    below_off = 1'b0;
    below_hp = 1'b0;
    above_on = 1'b1;
    wr(hotswap_pkg::ADDR_CONTROL, 8'h03);
    above_on = 1'b0;
    below_hp = 1'b1;
    settle();
    cmp_bit("gate off high power", 1'b0, gate);
    below_hp = 1'b0;
    above_on = 1'b1;
    wr(hotswap_pkg::ADDR_CONTROL, 8'h02);
    cmp_bit("gate disabled", 1'b0, gate);
    above_on = 1'b0;
    $display("test gate done");
    for (int c = 0; c < 2; c++) begin
      wr(hotswap_pkg::ADDR_CONTROL, 8'h01 | (8'h14 << c));
      settle();
      cmp_bit("bleed closed", 1'b1, mon[5+c]);
      en[c] = 1'b1;
      repeat (20) @(negedge clk);
      cmp_bit("held for discharge", 1'b0, mon[1+c]);
      cmp_bit("bleed open when on", 1'b0, mon[5+c]);
      low[c] = 1'b1;
      wait_mon(1 + c, 1'b1, 20, n);
      en[c] = 1'b0;
      low[c] = 1'b0;
      wr(hotswap_pkg::ADDR_CONTROL, 8'h01);
      cmp_bit("bleed bit clear", 1'b0, mon[5+c]);
    end
    $display("test discharge done");
    code = 5'($unsigned($random(seed)) % 31 + 1);
    fault_run(0, code);
    repeat (200) @(negedge clk);
    cmp_bit("latched off", 1'b0, pm);
    cmp_bit("flag held", 1'b1, flt[0]);
    chk_reg(hotswap_pkg::ADDR_STATUS, 8'h01 << hotswap_pkg::STAT_FLT_MAIN);
    en[0] = 1'b0;
    settle();
    en[0] = 1'b1;
    wait_mon(1, 1'b1, 50, n);
    cmp_bit("flag cleared", 1'b0, flt[0]);
    $display("test latch off done");
    wr(hotswap_pkg::ADDR_CONTROL, 8'h41);
    code = 5'($unsigned($random(seed)) % 4 + 1);
    fault_run(1, code);
    wait_mon(2, 1'b1, code * 100 * STEP + 50, n);
    cmp_bit("retry delay", 1'b1, n >= code * 100 * STEP - 20);
    $display("test retry done");
    test_done();
  end
endmodule
